// file: rtl/dsi_consts.svh
// Constants for the drive status indicator controller
`ifndef DSI_CONSTS_SVH
`define DSI_CONSTS_SVH

// Clock rate and derived time bases
`define DSI_CLK_HZ          25000000
`define DSI_STAGGER_SEC     10
`define DSI_STAGGER_CYC     (`DSI_STAGGER_SEC * `DSI_CLK_HZ)
`define DSI_READY_HALF_MS   250
`define DSI_READY_HALF_CYC  ((`DSI_READY_HALF_MS * `DSI_CLK_HZ) / 1000)
`define DSI_BEAT_HALF_MS    500
`define DSI_BEAT_HALF_CYC   ((`DSI_BEAT_HALF_MS * `DSI_CLK_HZ) / 1000)

`endif

// file: rtl/dsi_pkg.sv
// Types for the drive status indicator controller
package dsi_pkg;

    typedef enum logic [2:0]
    {
        DSI_IDLE,
        DSI_DELAY,
        DSI_SPINUP,
        DSI_READY,
        DSI_SPINDOWN,
        DSI_STOPPED
    } dsi_state_t;

    typedef struct packed
    {
        logic at_speed;
        logic heads_loaded;
        logic stopped;
        logic fault;
    } dsi_mech_t;

    typedef struct packed
    {
        logic start_cmd;
        logic spin_delay;
        logic [2:0] target_id;
    } dsi_strap_t;

endpackage

// file: rtl/dsi_blinker.sv
// Free-running square wave generator gated by an enable
`timescale 1ns/1ps
module dsi_blinker
    import dsi_pkg::*;
#(
    parameter int HALF_CYC = 1000
)
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      wave
);

    localparam int CW = $clog2(HALF_CYC + 1);

    logic [CW-1:0] count;

    // Count and wave freeze while run is low so the output holds its level
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            count <= '0;
            wave  <= 1'b0;
        end
        else if (run)
        begin
            if (count >= CW'(HALF_CYC - 1))
            begin
                count <= '0;
                wave  <= ~wave;
            end
            else
            begin
                count <= count + 1'b1;
            end
        end
    end

endmodule

// file: rtl/dsi_ctrl.sv
// Readiness, heartbeat and activity indicators plus spindle start control
// Notes on behaviour
// - Flash ready while spinning up until ready
// - Ready steady once up and fault free
// - Stop command after start flashes power-off
// - Heartbeat toggles while controller healthy
// - Heartbeat frozen on fault or diagnostics
// - Activity lit while executing a command
// - Activity dark with no pending command
// - Bezel activity mirrors socket activity
// - Start-command option: spindle moves only on command
// - Otherwise autostart, commands stop and restart
// - Spin-up delay waits target id times ten seconds
// - No options: spin up right away
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_ctrl
    import dsi_pkg::*;
#(
    parameter int STAGGER_CYC    = `DSI_STAGGER_CYC,
    parameter int READY_HALF_CYC = `DSI_READY_HALF_CYC,
    parameter int BEAT_HALF_CYC  = `DSI_BEAT_HALF_CYC
)
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire dsi_strap_t strap_pins,
    input  wire dsi_mech_t  mech_pins,
    input  wire logic       start_unit,
    input  wire logic       stop_unit,
    input  wire logic       cmd_busy,
    input  wire logic       ctl_fault,
    input  wire logic       ctl_diag,
    output logic            spindle_on,
    output logic            ready_led,
    output logic            beat_led,
    output logic            active_socket_led,
    output logic            active_bezel_led
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int PW = $bits(dsi_strap_t) + $bits(dsi_mech_t);

    logic [PW-1:0] pin_s1;
    logic [PW-1:0] pin_s2;
    dsi_strap_t    strap;
    dsi_mech_t     mech;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end
        else
        begin
            pin_s1 <= {strap_pins, mech_pins};
            pin_s2 <= pin_s1;
        end
    end

    assign strap = pin_s2[PW-1 -: $bits(dsi_strap_t)];
    assign mech  = pin_s2[$bits(dsi_mech_t)-1:0];

    // ************************************************************
    // Power sequence
    // ************************************************************
    dsi_state_t state;
    dsi_state_t next_state;
    logic [3:0] settle;
    logic       boot_done;
    logic [31:0] wait_cnt;
    logic [31:0] wait_goal;

    // Straps settle through the synchroniser before they are trusted
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            settle <= '0;
        else if (!settle[3])
            settle <= settle + 4'h1;
    end

    assign boot_done = settle[3];

    // Product fits 32 bits: 7 * 250e6 cycles at the default rate
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            wait_goal <= '0;
        else if (state == DSI_IDLE)
            wait_goal <= 32'(strap.target_id) * 32'(STAGGER_CYC);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            wait_cnt <= '0;
        else if (state == DSI_DELAY)
            wait_cnt <= wait_cnt + 32'h1;
        else
            wait_cnt <= '0;
    end

    always_comb
    begin
        next_state = state;
        case (state)
            DSI_IDLE:
            begin
                if (boot_done)
                begin
                    if (strap.start_cmd)
                        next_state = DSI_STOPPED;
                    else if (strap.spin_delay)
                        next_state = DSI_DELAY;
                    else
                        next_state = DSI_SPINUP;
                end
            end
            DSI_DELAY:
            begin
                if (wait_cnt >= wait_goal)
                    next_state = DSI_SPINUP;
            end
            DSI_SPINUP:
            begin
                if (stop_unit)
                    next_state = DSI_SPINDOWN;
                else if (mech.at_speed && mech.heads_loaded)
                    next_state = DSI_READY;
            end
            DSI_READY:
            begin
                if (stop_unit)
                    next_state = DSI_SPINDOWN;
            end
            DSI_SPINDOWN:
            begin
                if (mech.stopped)
                    next_state = DSI_STOPPED;
            end
            DSI_STOPPED:
            begin
                if (start_unit)
                    next_state = DSI_SPINUP;
            end
            default:
                next_state = DSI_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            state <= DSI_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            spindle_on <= 1'b0;
        else
            spindle_on <= (next_state == DSI_SPINUP) || (next_state == DSI_READY);
    end

    // ************************************************************
    // Indicators
    // ************************************************************
    logic flash;
    logic beat;
    logic flashing;
    logic healthy;

    assign flashing = (state == DSI_SPINUP) || (state == DSI_SPINDOWN);
    assign healthy  = !ctl_fault && !ctl_diag;

    dsi_blinker #(.HALF_CYC(READY_HALF_CYC)) u_flash
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (1'b1),
        .wave     (flash)
    );

    // Frozen blinker leaves the heartbeat at whatever level it last had
    dsi_blinker #(.HALF_CYC(BEAT_HALF_CYC)) u_beat
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (healthy),
        .wave     (beat)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            ready_led <= 1'b0;
        else if (flashing)
            ready_led <= flash;
        else
            ready_led <= (state == DSI_READY) && !mech.fault;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            beat_led <= 1'b0;
        else
            beat_led <= beat;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            active_socket_led <= 1'b0;
            active_bezel_led  <= 1'b0;
        end
        else
        begin
            active_socket_led <= cmd_busy;
            active_bezel_led  <= cmd_busy;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_active_follow;
        @(posedge core_clk) disable iff (!rstn)
        $past(rstn) |-> active_socket_led == $past(cmd_busy);
    endproperty
    a_active_follow: assert property (p_active_follow)
        else $error("activity led does not follow busy");

    property p_active_off;
        @(posedge core_clk) disable iff (!rstn)
        !cmd_busy |=> !active_socket_led;
    endproperty
    a_active_off: assert property (p_active_off)
        else $error("activity led lit while idle");

    property p_bezel_same;
        @(posedge core_clk) disable iff (!rstn)
        active_bezel_led == active_socket_led;
    endproperty
    a_bezel_same: assert property (p_bezel_same)
        else $error("bezel and socket differ");

    property p_ready_steady;
        @(posedge core_clk) disable iff (!rstn)
        (state == DSI_READY && !mech.fault) [*2] |=> ready_led;
    endproperty
    a_ready_steady: assert property (p_ready_steady)
        else $error("ready led not steady");

    property p_spinup_flash;
        @(posedge core_clk) disable iff (!rstn)
        flashing |=> ready_led == $past(flash);
    endproperty
    a_spinup_flash: assert property (p_spinup_flash)
        else $error("ready led not flashing");

    property p_stop_seq;
        @(posedge core_clk) disable iff (!rstn)
        (state == DSI_READY && stop_unit) |=> state == DSI_SPINDOWN ##1 !spindle_on;
    endproperty
    a_stop_seq: assert property (p_stop_seq)
        else $error("stop command ignored");

    property p_beat_frozen;
        @(posedge core_clk) disable iff (!rstn)
        (!healthy) [*3] |-> $stable(beat_led);
    endproperty
    a_beat_frozen: assert property (p_beat_frozen)
        else $error("heartbeat moved during fault");

    property p_beat_runs;
        @(posedge core_clk) disable iff (!rstn)
        $rose(beat) |-> healthy || $past(healthy);
    endproperty
    a_beat_runs: assert property (p_beat_runs)
        else $error("heartbeat toggled while unhealthy");

    property p_start_cmd_hold;
        @(posedge core_clk) disable iff (!rstn)
        (state == DSI_STOPPED && !start_unit) |=> state == DSI_STOPPED && !spindle_on;
    endproperty
    a_start_cmd_hold: assert property (p_start_cmd_hold)
        else $error("spindle started without command");

    property p_nodelay;
        @(posedge core_clk) disable iff (!rstn)
        (state == DSI_IDLE && boot_done && !strap.start_cmd && !strap.spin_delay)
            |=> state == DSI_SPINUP;
    endproperty
    a_nodelay: assert property (p_nodelay)
        else $error("immediate spin-up missed");

endmodule

// file: tb/dsi_initiator_model.sv
// Initiator and spindle mechanism model facing the indicator controller
`timescale 1ns/1ps
module dsi_initiator_model
    import dsi_pkg::*;
#(
    parameter int SPIN_CYC = 40
)
(
    input  wire logic core_clk,
    input  wire logic spindle_on,
    input  wire logic req_start,
    input  wire logic req_stop,
    input  wire logic req_busy,
    input  wire logic req_fault,
    output logic      start_unit,
    output logic      stop_unit,
    output logic      cmd_busy,
    output dsi_mech_t mech_pins
);
    int spin = 0;

    initial
    begin
        start_unit = 1'b0;
        stop_unit  = 1'b0;
        cmd_busy   = 1'b0;
    end

    // Commands are one-cycle pulses; only the bench decides when one is sent
    always @(posedge core_clk)
    begin
        start_unit <= req_start;
        stop_unit  <= req_stop;
        cmd_busy   <= req_busy;
    end

    // Disc inertia: speed ramps up and coasts down over SPIN_CYC cycles
    always @(posedge core_clk)
    begin
        if (spindle_on && spin < SPIN_CYC)
            spin <= spin + 1;
        else if (!spindle_on && spin > 0)
            spin <= spin - 1;
    end

    assign mech_pins = '{spindle_on && spin == SPIN_CYC, spindle_on && spin == SPIN_CYC,
                         spin == 0, req_fault};
endmodule

// file: tb/drive_status_indicator_ctrl_bench.sv
// Self-checking bench for the drive status indicator controller
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module drive_status_indicator_ctrl_bench
    import dsi_pkg::*;
;
    logic       core_clk  = 1'b0;
    logic       rstn      = 1'b0;
    logic       ctl_fault = 1'b0;
    logic       ctl_diag  = 1'b0;
    logic       req_start = 1'b0;
    logic       req_stop  = 1'b0;
    logic       req_busy  = 1'b0;
    logic       req_fault = 1'b0;
    dsi_strap_t strap_pins = '0;
    dsi_mech_t  mech_pins;
    logic       start_unit, stop_unit, cmd_busy;
    logic       spindle_on, ready_led, beat_led, act_s, act_b;
    int         fails = 0, total_checks = 0, cycles = 0, rt, bt, n;

    always #20 core_clk = ~core_clk;

    dsi_ctrl #(.STAGGER_CYC(20), .READY_HALF_CYC(4), .BEAT_HALF_CYC(6)) i_dsi_ctrl (
        .core_clk(core_clk), .rstn(rstn), .strap_pins(strap_pins), .mech_pins(mech_pins),
        .start_unit(start_unit), .stop_unit(stop_unit), .cmd_busy(cmd_busy),
        .ctl_fault(ctl_fault), .ctl_diag(ctl_diag), .spindle_on(spindle_on),
        .ready_led(ready_led), .beat_led(beat_led), .active_socket_led(act_s),
        .active_bezel_led(act_b));

    dsi_initiator_model i_dsi_initiator_model (
        .core_clk(core_clk), .spindle_on(spindle_on), .req_start(req_start),
        .req_stop(req_stop), .req_busy(req_busy), .req_fault(req_fault),
        .start_unit(start_unit), .stop_unit(stop_unit), .cmd_busy(cmd_busy),
        .mech_pins(mech_pins));

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            final_report();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    task automatic do_reset(input dsi_strap_t s);
        rstn <= 1'b0;
        strap_pins <= s;
        tick(10);
        rstn <= 1'b1;
    endtask

    // Counts LED changes; values read at the edge are the settled ones of the last cycle
    task automatic watch(input int k);
        logic r, b;
        r = ready_led;
        b = beat_led;
        rt = 0;
        bt = 0;
        repeat (k)
        begin
            tick(1);
            if (ready_led !== r) rt++;
            if (beat_led !== b) bt++;
            r = ready_led;
            b = beat_led;
        end
    endtask

    task automatic wait_spin(input logic v);
        n = 0;
        while (spindle_on !== v && n < 200)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic pulse(input bit stop);
        if (stop)
            req_stop <= 1'b1;
        else
            req_start <= 1'b1;
        tick(1);
        req_stop <= 1'b0;
        req_start <= 1'b0;
    endtask

    task automatic t_boot;
        do_reset('0);
        wait_spin(1'b1);
        `CHK(n <= 14, 1'b1)
        watch(16);
        `CHK(rt >= 2, 1'b1)
        tick(40);
        watch(20);
        `CHK(rt == 0, 1'b1)
        `CHK(ready_led, 1'b1)
        `CHK(bt >= 2, 1'b1)
        $display("test boot done");
    endtask

    task automatic t_active;
        req_busy <= 1'b1;
        tick(3);
        repeat (4)
        begin
            `CHK(act_s, 1'b1)
            `CHK(act_b, 1'b1)
            tick(1);
        end
        req_busy <= 1'b0;
        tick(3);
        `CHK(act_s, 1'b0)
        `CHK(act_b, 1'b0)
        $display("test activity done");
    endtask

    task automatic t_beat;
        for (int i = 0; i < 2; i++)
        begin
            if (i == 0)
                ctl_diag <= 1'b1;
            else
                ctl_fault <= 1'b1;
            tick(2);
            watch(30);
            `CHK(bt == 0, 1'b1)
            ctl_diag <= 1'b0;
            ctl_fault <= 1'b0;
            tick(2);
            watch(20);
            `CHK(bt >= 2, 1'b1)
        end
        $display("test heartbeat done");
    endtask

    // Fault pin crosses two synchroniser stages before the LED reacts
    task automatic t_fault;
        req_fault <= 1'b1;
        tick(4);
        `CHK(ready_led, 1'b0)
        req_fault <= 1'b0;
        tick(4);
        `CHK(ready_led, 1'b1)
        $display("test ready fault done");
    endtask

    task automatic t_stop;
        pulse(1'b1);
        tick(3);
        `CHK(spindle_on, 1'b0)
        watch(16);
        `CHK(rt >= 2, 1'b1)
        tick(50);
        pulse(1'b0);
        wait_spin(1'b1);
        `CHK(n <= 5, 1'b1)
        $display("test stop restart done");
    endtask

    task automatic t_startcmd;
        do_reset('{1'b1, 1'b0, 3'h0});
        tick(60);
        `CHK(spindle_on, 1'b0)
        pulse(1'b0);
        wait_spin(1'b1);
        `CHK(n <= 5, 1'b1)
        $display("test start command done");
    endtask

    // Target 3 waits three stagger units of 20 cycles after the strap settle time
    task automatic t_delay;
        do_reset('{1'b0, 1'b1, 3'h3});
        wait_spin(1'b1);
        `CHK(n >= 60, 1'b1)
        `CHK(n <= 75, 1'b1)
        $display("test spin delay done");
    endtask

    initial
    begin
        t_boot();
        t_active();
        t_beat();
        t_fault();
        t_stop();
        t_startcmd();
        t_delay();
        final_report();
    end
endmodule
